//--- core/regfile_defs.svh
`ifndef REGFILE_DEFS_SVH
`define REGFILE_DEFS_SVH
`define TOTAL_CPU_REGS   13
`define BANKED_REGS      7
`define BANK_COUNT       2
`define WORD_W           16
`define BYTE_W           8
`define LONG_W           32
`define IDX_W            3
`define RESET_WORD       16'h0000
`endif

//--- core/regfile_pkg.sv
package regfile_pkg;
	// register selector for word access
	typedef enum logic [2:0] {
		SEL_DATA_0,
		SEL_DATA_1,
		SEL_DATA_2,
		SEL_DATA_3,
		SEL_ADDR_0,
		SEL_ADDR_1,
		SEL_FRAME_BASE,
		SEL_NONE
	} reg_sel_t;
	// access width
	typedef enum logic [1:0] {
		ACC_WORD,
		ACC_LOW_BYTE,
		ACC_HIGH_BYTE,
		ACC_LONG
	} acc_size_t;
endpackage

//--- core/reg_bank.sv
`timescale 1ns/1ps
`include "regfile_defs.svh"
module reg_bank (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [6:0]  word_we,
	input  wire logic [6:0]  low_we,
	input  wire logic [6:0]  high_we,
	input  wire logic [15:0] wdata [0:6],
	output logic      [15:0] rdata [0:6]
);
	logic [15:0] store_reg  [0:6];
	logic [15:0] store_next [0:6];

	always_comb begin
		for (int i = 0; i < `BANKED_REGS; i++) begin
			store_next[i] = store_reg[i];
			if (word_we[i]) begin
				store_next[i] = wdata[i];
			end else begin
				// byte writes keep the other half
				if (low_we[i]) begin
					store_next[i][7:0] = wdata[i][7:0];
				end
				if (high_we[i]) begin
					store_next[i][15:8] = wdata[i][15:8];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < `BANKED_REGS; i++) begin
			store_reg[i] <= rst ? `RESET_WORD : store_next[i];
		end
	end

	assign rdata = store_reg;
endmodule

//--- core/cpu_banked_register_file.sv
`timescale 1ns/1ps
`include "regfile_defs.svh"
//Contract
// - the core keeps thirteen registers, of which the four data, two address and frame base registers form a bank.
// - there are two bank copies; only the selected one is visible and the other keeps its contents.
// - the four data registers are 16 bits and serve as source and destination of transfers and operations.
// - data registers 0 and 1 can each be read and written as separate high and low bytes.
// - data registers 2:0 and 3:1 combine into 32-bit registers, the higher-numbered one as upper half.
module cpu_banked_register_file (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  bank_sel,
	input  wire logic                  wr_en,
	input  wire regfile_pkg::reg_sel_t wr_sel,
	input  wire regfile_pkg::acc_size_t wr_size,
	input  wire logic [31:0]           wr_data,
	input  wire regfile_pkg::reg_sel_t rd_a_sel,
	input  wire regfile_pkg::acc_size_t rd_a_size,
	input  wire regfile_pkg::reg_sel_t rd_b_sel,
	input  wire regfile_pkg::acc_size_t rd_b_size,
	output logic [31:0]                rd_a_data,
	output logic [31:0]                rd_b_data
);
	import regfile_pkg::*;

	// the remaining six core registers live outside this block
	localparam int UNBANKED = `TOTAL_CPU_REGS - `BANKED_REGS;

	logic [6:0]  word_we  [0:1];
	logic [6:0]  low_we   [0:1];
	logic [6:0]  high_we  [0:1];
	logic [15:0] wdata    [0:6];
	logic [15:0] bank_rd  [0:1][0:6];
	logic [15:0] vis      [0:6];
	logic [31:0] rd_a_next;
	logic [31:0] rd_b_next;
	logic [31:0] rd_a_reg;
	logic [31:0] rd_b_reg;

	genvar b;
	generate
		for (b = 0; b < `BANK_COUNT; b++) begin : g_bank
			reg_bank u_bank (
				.clk     (clk),
				.rst     (rst),
				.word_we (word_we[b]),
				.low_we  (low_we[b]),
				.high_we (high_we[b]),
				.wdata   (wdata),
				.rdata   (bank_rd[b])
			);
		end
	endgenerate

	// write decode: only the selected copy sees a strobe
	always_comb begin
		logic [6:0] w;
		logic [6:0] l;
		logic [6:0] h;
		w = 7'h00;
		l = 7'h00;
		h = 7'h00;
		for (int i = 0; i < `BANKED_REGS; i++) begin
			wdata[i] = wr_data[15:0];
		end
		if (wr_en && wr_sel != SEL_NONE) begin
			unique case (wr_size)
				ACC_WORD: begin
					w[wr_sel] = 1'b1;
				end
				ACC_LOW_BYTE: begin
					if (wr_sel == SEL_DATA_0 || wr_sel == SEL_DATA_1) begin
						l[wr_sel] = 1'b1;
					end
				end
				ACC_HIGH_BYTE: begin
					if (wr_sel == SEL_DATA_0 || wr_sel == SEL_DATA_1) begin
						h[wr_sel] = 1'b1;
						wdata[wr_sel] = {wr_data[7:0], 8'h00};
					end
				end
				ACC_LONG: begin
					// pair 2:0 when 0 or 2 is named, 3:1 when 1 or 3 is named
					if (wr_sel == SEL_DATA_0 || wr_sel == SEL_DATA_2) begin
						w[0] = 1'b1;
						w[2] = 1'b1;
						wdata[0] = wr_data[15:0];
						wdata[2] = wr_data[31:16];
					end else if (wr_sel == SEL_DATA_1 || wr_sel == SEL_DATA_3) begin
						w[1] = 1'b1;
						w[3] = 1'b1;
						wdata[1] = wr_data[15:0];
						wdata[3] = wr_data[31:16];
					end
				end
			endcase
		end
		word_we[0] = bank_sel ? 7'h00 : w;
		low_we[0]  = bank_sel ? 7'h00 : l;
		high_we[0] = bank_sel ? 7'h00 : h;
		word_we[1] = bank_sel ? w : 7'h00;
		low_we[1]  = bank_sel ? l : 7'h00;
		high_we[1] = bank_sel ? h : 7'h00;
	end

	always_comb begin
		for (int i = 0; i < `BANKED_REGS; i++) begin
			vis[i] = bank_sel ? bank_rd[1][i] : bank_rd[0][i];
		end
	end

	function automatic logic [31:0] read_port(input reg_sel_t sel, input acc_size_t size,
	                                          input logic [15:0] v [0:6]);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (sel != SEL_NONE) begin
			unique case (size)
				ACC_WORD: r = {16'h0000, v[sel]};
				ACC_LOW_BYTE: begin
					if (sel == SEL_DATA_0 || sel == SEL_DATA_1) begin
						r = {24'h00_0000, v[sel][7:0]};
					end
				end
				ACC_HIGH_BYTE: begin
					if (sel == SEL_DATA_0 || sel == SEL_DATA_1) begin
						r = {24'h00_0000, v[sel][15:8]};
					end
				end
				ACC_LONG: begin
					if (sel == SEL_DATA_0 || sel == SEL_DATA_2) begin
						r = {v[2], v[0]};
					end else if (sel == SEL_DATA_1 || sel == SEL_DATA_3) begin
						r = {v[3], v[1]};
					end
				end
			endcase
		end
		return r;
	endfunction

	always_comb begin
		rd_a_next = read_port(rd_a_sel, rd_a_size, vis);
		rd_b_next = read_port(rd_b_sel, rd_b_size, vis);
	end

	always_ff @(posedge clk) begin
		rd_a_reg <= rst ? 32'h0000_0000 : rd_a_next;
		rd_b_reg <= rst ? 32'h0000_0000 : rd_b_next;
	end

	assign rd_a_data = rd_a_reg;
	assign rd_b_data = rd_b_reg;
endmodule

//--- bench/core_driver.sv
`timescale 1ns/1ps
module core_driver (
	input  wire logic                   clk,
	output logic                        wr_en,
	output regfile_pkg::reg_sel_t       wr_sel,
	output regfile_pkg::acc_size_t      wr_size,
	output logic [31:0]                 wr_data
);
	import regfile_pkg::*;
	initial begin
		wr_en = 1'b0;
		wr_sel = SEL_NONE;
		wr_size = ACC_WORD;
		wr_data = 32'h0;
	end
	// data is inverted on release so a stale word never looks valid
	task automatic wr(input reg_sel_t s, input acc_size_t z, input logic [31:0] d);
		@(posedge clk) #1;
		wr_en = 1'b1;
		wr_sel = s;
		wr_size = z;
		wr_data = d;
		@(posedge clk) #1;
		wr_en = 1'b0;
		wr_data = ~d;
	endtask
endmodule

//--- bench/rf_props_properties.sv
`timescale 1ns/1ps
module rf_props (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire regfile_pkg::reg_sel_t  rd_a_sel,
	input wire regfile_pkg::acc_size_t rd_a_size,
	input wire logic [31:0]            rd_a_data
);
	import regfile_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RST: assert property (disable iff (1'b0) rst |=> rd_a_data == 0) else $error("not cleared");
	AST_NONE: assert property (rd_a_sel == SEL_NONE |=> rd_a_data == 0) else $error("no such reg");
	AST_WORD: assert property (rd_a_size == ACC_WORD |=> rd_a_data[31:16] == 0) else $error("word wide");
	AST_BYTE: assert property (^rd_a_size |=> rd_a_data[31:8] == 0) else $error("byte wide");
	AST_BREF: assert property (^rd_a_size && rd_a_sel > SEL_DATA_1 |=> rd_a_data == 0)
		else $error("byte not refused");
	AST_LONG: assert property (rd_a_size == ACC_LONG && rd_a_sel > SEL_DATA_3 |=> rd_a_data == 0)
		else $error("long not refused");
endmodule
bind cpu_banked_register_file rf_props props (.clk, .rst, .rd_a_sel, .rd_a_size, .rd_a_data);

//--- bench/tb_cpu_banked_register_file.sv
`timescale 1ns/1ps
module tb_cpu_banked_register_file;
	import regfile_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bank_sel = 1'b0;
	logic wr_en;
	reg_sel_t wr_sel, rd_a_sel = SEL_NONE, rd_b_sel = SEL_NONE;
	acc_size_t wr_size, rd_a_size = ACC_WORD, rd_b_size = ACC_WORD;
	logic [31:0] wr_data, rd_a_data, rd_b_data;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	always #10 clk = ~clk;
	core_driver drv (.clk, .wr_en, .wr_sel, .wr_size, .wr_data);
	cpu_banked_register_file dut (.clk, .rst, .bank_sel, .wr_en, .wr_sel, .wr_size, .wr_data, .rd_a_sel,
		.rd_a_size, .rd_b_sel, .rd_b_size, .rd_a_data, .rd_b_data);
	task automatic stop_test;
		$display("mismatches %0d of %0d checks", miscompares, num_checks);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// both read ports are compared; each port may name its own register
	task automatic rd_ab(input reg_sel_t sa, input acc_size_t za, input logic [31:0] ea,
	                     input reg_sel_t sb, input acc_size_t zb, input logic [31:0] eb);
		rd_a_sel = sa;
		rd_a_size = za;
		rd_b_sel = sb;
		rd_b_size = zb;
		@(posedge clk) #1;
		num_checks++;
		if (rd_a_data !== ea || rd_b_data !== eb) begin
			miscompares++;
			$display("MISMATCH %0t %h %h %h %h", $time, rd_a_data, ea, rd_b_data, eb);
		end
	endtask
	task automatic rd(input reg_sel_t s, input acc_size_t z, input logic [31:0] e);
		rd_ab(s, z, e, s, z, e);
	endtask
	task automatic t_word;
		for (int i = 0; i < 7; i++)
			drv.wr(reg_sel_t'(i), ACC_WORD, 32'hFFFF0000 + 32'h1111 * (i + 1));
		for (int i = 0; i < 8; i++)
			rd(reg_sel_t'(i), ACC_WORD, i < 7 ? 32'h1111 * (i + 1) : 32'h0);
		$display("word done");
	endtask
	task automatic t_bank;
		bank_sel = 1'b1;
		drv.wr(SEL_DATA_0, ACC_WORD, 32'h5A5A);
		for (int i = 0; i < 4; i++) begin
			bank_sel = ~bank_sel;
			rd(SEL_DATA_0, ACC_WORD, bank_sel ? 32'h5A5A : 32'h1111);
		end
		$display("bank done");
	endtask
	task automatic t_bytes;
		bank_sel = 1'b0;
		drv.wr(SEL_DATA_1, ACC_LOW_BYTE, 32'hAB3C);
		rd(SEL_DATA_1, ACC_WORD, 32'h223C);
		drv.wr(SEL_DATA_1, ACC_HIGH_BYTE, 32'hCDC3);
		rd(SEL_DATA_1, ACC_HIGH_BYTE, 32'hC3);
		drv.wr(SEL_ADDR_0, ACC_LOW_BYTE, 32'h77);
		rd(SEL_ADDR_0, ACC_LOW_BYTE, 32'h0);
		rd(SEL_ADDR_0, ACC_WORD, 32'h5555);
		$display("byte done");
	endtask
	task automatic t_long;
		drv.wr(SEL_DATA_0, ACC_LONG, 32'h12345678);
		rd(SEL_DATA_2, ACC_LONG, 32'h12345678);
		rd(SEL_FRAME_BASE, ACC_LONG, 32'h0);
		rd_ab(SEL_DATA_2, ACC_WORD, 32'h1234, SEL_DATA_0, ACC_HIGH_BYTE, 32'h56);
		$display("long done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		rd(SEL_DATA_3, ACC_LONG, 32'h0);
		t_word;
		t_bank;
		t_bytes;
		t_long;
		stop_test;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			stop_test;
		end
	end
endmodule
